// >>> rtl/pss_regs.svh
/*
 Timing and field constants for the power-state sequencer.
 Assumes inclusion by bare name from rtl/.
*/
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_CLK_MHZ        40
`define PSS_PLL_LOCK_NS    2000
`define PSS_PLL_LOCK_CYC   ((`PSS_PLL_LOCK_NS * `PSS_CLK_MHZ + 999) / 1000)
`define PSS_DRAM_ACTIVE    2'h0
`define PSS_DRAM_SELF_REF  2'h1
`define PSS_DRAM_OFF       2'h2
`define PSS_CNT_ZERO       16'h0000
`define PSS_CNT_ONE        16'h0001
`endif

// >>> rtl/pss_pkg.sv
/*
 Types shared by the power-state sequencer.
 Assumes nothing of its surroundings.
*/
package pss_pkg;
  typedef enum logic [2:0] {
    PSS_ACTIVE  = 3'h0,
    PSS_DEEP    = 3'h1,
    PSS_RELOCK  = 3'h2,
    PSS_POS     = 3'h3,
    PSS_STR     = 3'h4,
    PSS_STD     = 3'h5
  } pss_state_t;
endpackage

// >>> rtl/pss_lock_timer.sv
/*
 PLL lock wait counter: counts down after a start pulse, flags done.
 Assumes a free-running clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_lock_timer #(
  parameter logic [15:0] LOCK_CYC = 16'(`PSS_PLL_LOCK_CYC)
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_start,
  output logic      o_done
);
  logic [15:0] cnt_reg;

  // Count down the lock wait
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= `PSS_CNT_ZERO;
    end else if (i_start) begin
      cnt_reg <= LOCK_CYC;
    end else if (cnt_reg != `PSS_CNT_ZERO) begin
      cnt_reg <= cnt_reg - `PSS_CNT_ONE;
    end
  end

  // Done when the count has just expired
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt_reg == `PSS_CNT_ONE) && !i_start;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pss_sequencer.sv
/*
 Power-state sequencer: maps CPU C-states and sleep states onto DRAM mode,
 sense-amp disable, hub link power state and PLL enables.
 Assumes all inputs synchronous to i_mclk and a full reset on power-up.
*/
// Function
// - In C0 and C1 all PLLs run, hub link active, DRAM active.
// - C2 disables sense amps except during host transactions; on in C0/C1.
// - Reading the level-3 register moves from C0 to C3.
// - C3 puts DRAM in self refresh, hub low power, sense amps off.
// - With shutdown enabled, deep-sleep input decides when PLLs turn off.
// - C4 is handled exactly like C3.
// - Power-on-suspend holds self refresh, hub low power, both PLLs off.
// - DRAM is in self refresh before suspend-to-RAM is entered.
// - Suspend-to-disk turns DRAM off, no contents kept.
// - The S2 sleep state is not supported.
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_sequencer
  import pss_pkg::*;
#(
  parameter logic [15:0] LOCK_CYC = 16'(`PSS_PLL_LOCK_CYC)
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // Processor and I/O hub power signals
  input  wire logic       i_stop_clock_request_n,
  input  wire logic       i_deep_sleep_request_n,
  input  wire logic       i_level3_read,
  input  wire logic       i_cpu_wake,
  input  wire logic       i_host_txn,
  // Sleep requests
  input  wire logic       i_mobile_power_on_suspend,
  input  wire logic       i_suspend_to_ram,
  input  wire logic       i_suspend_to_disk,
  input  wire logic       i_suspend_s2,
  input  wire logic       i_resume,
  // Configuration
  input  wire logic       i_pll_shutdown_en,
  // DRAM, bus and link controls
  output logic [1:0]      o_dram_mode,
  output logic            o_sense_amp_disable,
  output logic            o_hub_low_power,
  output logic            o_host_pll_en,
  output logic            o_agp_hub_pll_en,
  output logic            o_traffic_resume,
  output logic [2:0]      o_state
);
  pss_state_t state_reg;
  pss_state_t state_next;
  logic       lock_start;
  logic       lock_done;
  logic       pll_off;
  logic       pll_off_next;

  // Lock wait after PLL restart
  pss_lock_timer #(
    .LOCK_CYC (LOCK_CYC)
  ) u_lock (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_start (lock_start),
    .o_done  (lock_done)
  );

  // Next state selection
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PSS_ACTIVE: begin
        if (i_level3_read) begin
          state_next = PSS_DEEP;
        end
      end
      PSS_DEEP: begin
        // C4 takes the same path as C3
        if (i_suspend_to_disk) begin
          state_next = PSS_STD;
        end else if (i_suspend_to_ram) begin
          state_next = PSS_STR;
        end else if (i_mobile_power_on_suspend) begin
          state_next = PSS_POS;
        end else if (i_cpu_wake) begin
          state_next = pll_off ? PSS_RELOCK : PSS_ACTIVE;
        end
      end
      PSS_POS: begin
        if (i_resume) begin
          state_next = PSS_RELOCK;
        end
      end
      PSS_STR, PSS_STD: begin
        // Left only through a full reset
        state_next = state_reg;
      end
      PSS_RELOCK: begin
        if (lock_done) begin
          state_next = PSS_ACTIVE;
        end
      end
      default: begin
        state_next = PSS_ACTIVE;
      end
    endcase
  end

  // State register; S2 requests are ignored
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= PSS_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // PLL shutdown decision in deep states
  always_comb begin
    pll_off_next = 1'b0;
    case (state_next)
      PSS_DEEP: begin
        // Once off, stay off until the exit path relocks them
        pll_off_next = i_pll_shutdown_en && (pll_off || !i_deep_sleep_request_n);
      end
      PSS_POS, PSS_STR, PSS_STD: pll_off_next = 1'b1;
      default:    pll_off_next = 1'b0;
    endcase
  end

  // PLL off flag
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pll_off <= 1'b0;
    end else begin
      pll_off <= pll_off_next;
    end
  end

  // Start lock timer on entering relock
  assign lock_start = (state_next == PSS_RELOCK) && (state_reg != PSS_RELOCK);

  // PLL enables
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_pll_en    <= 1'b1;
      o_agp_hub_pll_en <= 1'b1;
    end else begin
      o_host_pll_en    <= !pll_off_next;
      o_agp_hub_pll_en <= !pll_off_next;
    end
  end

  // DRAM mode
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dram_mode <= `PSS_DRAM_ACTIVE;
    end else begin
      case (state_next)
        PSS_ACTIVE: o_dram_mode <= `PSS_DRAM_ACTIVE;
        PSS_STD:    o_dram_mode <= `PSS_DRAM_OFF;
        default:    o_dram_mode <= `PSS_DRAM_SELF_REF;
      endcase
    end
  end

  // Hub link power and traffic gate
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hub_low_power  <= 1'b0;
      o_traffic_resume <= 1'b1;
    end else begin
      o_hub_low_power  <= (state_next != PSS_ACTIVE);
      o_traffic_resume <= (state_next == PSS_ACTIVE);
    end
  end

  // Sense amps: off in C2 unless a transaction, off in deep states
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sense_amp_disable <= 1'b0;
    end else if (state_next != PSS_ACTIVE) begin
      o_sense_amp_disable <= 1'b1;
    end else begin
      o_sense_amp_disable <= !i_stop_clock_request_n && !i_host_txn;
    end
  end

  // State view
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_state <= PSS_ACTIVE;
    end else begin
      o_state <= state_next;
    end
  end

  // Checks
  sequence s_deep_entry;
    (state_reg == PSS_ACTIVE) && i_level3_read;
  endsequence

  sequence s_deep_outputs;
    (o_dram_mode == `PSS_DRAM_SELF_REF) && o_hub_low_power && o_sense_amp_disable;
  endsequence

  chk_level3_entry: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_deep_entry |=> s_deep_outputs)
    else $error("level-3 read did not enter deep state");

  chk_active_outputs: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_state == PSS_ACTIVE) |-> o_host_pll_en && o_agp_hub_pll_en && !o_hub_low_power
      && (o_dram_mode == `PSS_DRAM_ACTIVE))
    else $error("active state outputs wrong");

  chk_c2_sense_amp: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_next == PSS_ACTIVE && i_stop_clock_request_n) |=> !o_sense_amp_disable)
    else $error("sense amps off outside C2");

  chk_c2_txn_on: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_next == PSS_ACTIVE && i_host_txn) |=> !o_sense_amp_disable)
    else $error("sense amps off during transaction");

  chk_pll_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_next == PSS_DEEP && !i_pll_shutdown_en) |=> o_host_pll_en)
    else $error("PLL stopped with shutdown disabled");

  chk_pll_deep_sleep_request_n: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_next == PSS_DEEP && i_pll_shutdown_en && !i_deep_sleep_request_n)
      |=> !o_host_pll_en && !o_agp_hub_pll_en)
    else $error("PLL not stopped on deep sleep");

  chk_pos_outputs: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_state == PSS_POS) |-> !o_host_pll_en && o_hub_low_power
      && (o_dram_mode == `PSS_DRAM_SELF_REF))
    else $error("suspend outputs wrong");

  chk_std_dram_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_state == PSS_STD) |-> (o_dram_mode == `PSS_DRAM_OFF))
    else $error("DRAM not off in suspend to disk");

  chk_str_path: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == PSS_STR) |-> $past(state_reg) inside {PSS_DEEP, PSS_STR})
    else $error("suspend to RAM entered without self refresh");

  chk_relock_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == PSS_RELOCK && !lock_done) |=> !o_traffic_resume
      && (o_dram_mode == `PSS_DRAM_SELF_REF))
    else $error("traffic resumed before PLL lock");

  chk_s2_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == PSS_DEEP && i_suspend_s2 && !i_suspend_to_disk && !i_suspend_to_ram
      && !i_mobile_power_on_suspend && !i_cpu_wake) |=> (state_reg == PSS_DEEP))
    else $error("S2 request changed the deep state");
endmodule
`default_nettype wire

// >>> test/pss_cpu_model.sv
/*
 Processor and I/O hub model driving the power-state signals.
 Assumes bench requests change shortly after the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pss_cpu_model
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // Bench requests and sequencer state
  input  wire logic       i_c2,
  input  wire logic       i_deep,
  input  wire logic       i_txn,
  input  wire logic [2:0] i_state,
  // Power-state signals
  output logic            o_stop_n,
  output logic            o_deep_sleep_request_n_n,
  output logic            o_txn
);
  // Agents move their signals only on the clock edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stop_n  <= 1'b1;
      o_deep_sleep_request_n_n <= 1'b1;
      o_txn     <= 1'b0;
    end else begin
      o_stop_n  <= !(i_c2 || i_deep);
      o_deep_sleep_request_n_n <= !(i_deep && i_state == PSS_DEEP); // Deep sleep only once asleep
      o_txn     <= i_txn && i_state == PSS_ACTIVE;
    end
  end
endmodule
`default_nettype wire

// >>> test/pss_sequencer_tb.sv
/*
 Self-checking bench for the power-state sequencer.
 Assumes the lock wait parameter is shortened to 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module power_state_sequencer_tb
  import pss_pkg::*;
;
  localparam int LOCK = 4;
  logic mclk = 0, rst_n = 0, c2 = 0, deep = 0, txn = 0, l3 = 0, wake = 0;
  logic pos = 0, str = 0, std = 0, s2 = 0, resume = 0, en = 0;
  logic stop_n, deep_sleep_request_n_n, txn_w, sa, hub, hpll, apll, traf;
  logic [1:0] dram;
  logic [2:0] st;
  int fails = 0, n_checks = 0, cyc = 0, c;

  // Clock and watchdog
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end

  pss_cpu_model i_pss_cpu_model (.i_mclk(mclk), .i_rst_n(rst_n), .i_c2(c2), .i_deep(deep),
    .i_txn(txn), .i_state(st), .o_stop_n(stop_n), .o_deep_sleep_request_n_n(deep_sleep_request_n_n), .o_txn(txn_w));
  pss_sequencer #(.LOCK_CYC(16'h0004)) i_pss_sequencer (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_stop_clock_request_n(stop_n), .i_deep_sleep_request_n(deep_sleep_request_n_n), .i_level3_read(l3),
    .i_cpu_wake(wake), .i_host_txn(txn_w), .i_mobile_power_on_suspend(pos),
    .i_suspend_to_ram(str), .i_suspend_to_disk(std), .i_suspend_s2(s2), .i_resume(resume),
    .i_pll_shutdown_en(en), .o_dram_mode(dram), .o_sense_amp_disable(sa),
    .o_hub_low_power(hub), .o_host_pll_en(hpll), .o_agp_hub_pll_en(apll),
    .o_traffic_resume(traf), .o_state(st));

  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic wait_st(logic [2:0] s);
    c = 0;
    while (st !== s && c < 40) begin
      tick();
      c++;
    end
  endtask
  task automatic do_reset();
    rst_n = 0;
    tick(20);
    rst_n = 1;
    tick();
  endtask
  // Fully-on outputs
  task automatic chk_on();
    `CHK("dram", `PSS_DRAM_ACTIVE, dram)
    `CHK("hub", 1'b0, hub)
    `CHK("plls", 2'b11, {hpll, apll})
    `CHK("traffic", 1'b1, traf)
  endtask
  task automatic enter_deep(logic e);
    en = e;
    deep = 1;
    l3 = 1;
    tick();
    l3 = 0;
    wait_st(PSS_DEEP);
    tick(3);
  endtask
  // Stop-grant sense amps, stray requests ignored
  task automatic t_c2();
    c2 = 1;
    tick(3);
    `CHK("sa_c2", 1'b1, sa)
    txn = 1;
    tick(3);
    `CHK("sa_txn", 1'b0, sa)
    txn = 0;
    c2 = 0;
    {s2, str, std, pos} = 4'hf;
    tick(3);
    {s2, str, std, pos} = 4'h0;
    `CHK("sa_c0", 1'b0, sa)
    `CHK("st_stray", PSS_ACTIVE, st)
    chk_on();
  endtask
  // Level-3 read, deep state, wake with or without relock
  task automatic t_deep(logic e);
    enter_deep(e);
    s2 = 1;
    tick();
    s2 = 0;
    `CHK("st_deep", PSS_DEEP, st)
    `CHK("traffic_deep", 1'b0, traf)
    `CHK("dram_deep", `PSS_DRAM_SELF_REF, dram)
    `CHK("hub_deep", 1'b1, hub)
    `CHK("sa_deep", 1'b1, sa)
    `CHK("plls_deep", {!e, !e}, {hpll, apll})
    wake = 1;
    tick();
    wake = 0;
    deep = 0;
    if (e) begin
      wait_st(PSS_RELOCK);
      `CHK("plls_relock", 2'b11, {hpll, apll})
      `CHK("dram_relock", `PSS_DRAM_SELF_REF, dram)
      wait_st(PSS_ACTIVE);
      `CHK("lock_wait", 1'b1, c >= LOCK - 1)
    end else begin
      wait_st(PSS_ACTIVE);
    end
    chk_on();
  endtask
  // Power-on suspend and resume
  task automatic t_pos();
    enter_deep(1'b0);
    pos = 1;
    tick();
    pos = 0;
    wait_st(PSS_POS);
    `CHK("dram_pos", `PSS_DRAM_SELF_REF, dram)
    `CHK("hub_pos", 1'b1, hub)
    `CHK("plls_pos", 2'b00, {hpll, apll})
    resume = 1;
    tick();
    resume = 0;
    deep = 0;
    wait_st(PSS_ACTIVE);
    chk_on();
  endtask
  // Suspend to RAM or disk, left by reset
  task automatic t_sleep(logic disk);
    enter_deep(1'b0);
    {std, str} = {disk, !disk};
    tick();
    {std, str} = 2'b00;
    deep = 0;
    wait_st(disk ? PSS_STD : PSS_STR);
    `CHK("dram_sleep", disk ? `PSS_DRAM_OFF : `PSS_DRAM_SELF_REF, dram)
    do_reset();
    chk_on();
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset();
    chk_on();
    t_c2();
    t_deep(1'b0);
    t_deep(1'b1);
    t_pos();
    t_sleep(1'b0);
    t_sleep(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
